// >>> src/aimux_top.sv
// analog input mux select register bank with apb slave and route decode
// assumes apb master on core_clk; route outputs drive analog switches
//
// Contract
// - channel register upper nibble reads zero, ignored
// - four-bit channel code, readable, resets zero
// - single-ended decode of channel codes
// - pair bits turn codes into differential pairs
// - differential amplifier routes reference to negative
// - amplifier output to positive input when chosen
// - one enable bit per port pin, reset zero
// - any pin enable combination accepted
// - even pins to even group, odd to odd
// - even and odd enabled together short
// - four pair-config bits, set means differential
// - differential results are twos complement
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module aimux_top #(
    parameter int PINS      = aimux_pkg::PINS_W,
    parameter int CODE_BITS = aimux_pkg::CODE_W,
    parameter int PAIR_BITS = aimux_pkg::PAIR_W
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    output aimux_pkg::aimux_route_t    route,
    output logic                       result_twos_complement
);
    aimux_pkg::aimux_state_t s_q;
    aimux_pkg::aimux_state_t s_d;
    aimux_pkg::aimux_route_t r;
    logic                    setup;
    logic                    mapped;
    logic [CODE_BITS-1:0]    code;
    logic [PAIR_BITS-1:0]    pc;
    logic [PINS-1:0]         even_sw;
    logic [PINS-1:0]         odd_sw;

    // the register layout is fixed by the package; other widths cannot fit
    if (PINS != aimux_pkg::PINS_W || CODE_BITS != aimux_pkg::CODE_W ||
        PAIR_BITS != aimux_pkg::PAIR_W) begin : g_bad_width
        $error("aimux_top widths must match the register layout");
    end

    // per-pin parity split; each enabled pin feeds exactly one group
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        if (i % 2 == 0) begin : g_even
            assign even_sw[i] = s_q.port_pin_en[i];
            assign odd_sw[i]  = 1'b0;
        end else begin : g_odd
            assign even_sw[i] = 1'b0;
            assign odd_sw[i]  = s_q.port_pin_en[i];
        end
    end

    // zero wait states; unmapped addresses answer with pslverr
    assign setup  = psel && !penable;
    assign mapped = (paddr == aimux_pkg::ADDR_PORT_PIN_EN) ||
                    (paddr == aimux_pkg::ADDR_CHANNEL_SEL) ||
                    (paddr == aimux_pkg::ADDR_PAIR_CONFIG);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = s_q.prdata;
    assign route   = s_q.route;
    assign result_twos_complement = s_q.route.differential;

    // next state: register writes, read data, and route decode
    always_comb begin
        s_d  = s_q;
        code = s_q.channel_code;
        pc   = s_q.pair_cfg;
        // write takes effect in the access phase only
        if (psel && penable && pwrite && pstrb[0]) begin
            case (paddr)
                aimux_pkg::ADDR_PORT_PIN_EN:
                    s_d.port_pin_en = pwdata[7:0];
                aimux_pkg::ADDR_CHANNEL_SEL:
                    s_d.channel_code = pwdata[3:0];
                aimux_pkg::ADDR_PAIR_CONFIG:
                    s_d.pair_cfg = pwdata[3:0];
                default: ;
            endcase
        end
        // read data captured in setup so it is stable in access
        if (setup && !pwrite) begin
            case (paddr)
                aimux_pkg::ADDR_PORT_PIN_EN:
                    s_d.prdata = {24'h000000, s_q.port_pin_en};
                aimux_pkg::ADDR_CHANNEL_SEL:
                    s_d.prdata = {28'h0000000, s_q.channel_code};
                aimux_pkg::ADDR_PAIR_CONFIG:
                    s_d.prdata = {28'h0000000, s_q.pair_cfg};
                default:
                    s_d.prdata = 32'h00000000;
            endcase
        end

        // route decode from the current registers; one cycle behind writes
        r = '0;
        r.pos_src = aimux_pkg::AIMUX_SRC_NONE;
        r.neg_src = aimux_pkg::AIMUX_SRC_AGND;
        if (code[3]) begin
            r.pos_src = aimux_pkg::AIMUX_SRC_TEMP;
        end else begin
            case (code)
                aimux_pkg::CODE_AIN0: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_AIN0;
                    if (pc[aimux_pkg::PAIR_AIN01]) begin
                        r.neg_src = aimux_pkg::AIMUX_SRC_AIN1;
                        r.differential = 1'b1;
                    end
                end
                aimux_pkg::CODE_AIN1: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_AIN1;
                    // second code of a pair has no defined input
                    if (pc[aimux_pkg::PAIR_AIN01]) begin
                        r.pos_src = aimux_pkg::AIMUX_SRC_NONE;
                        r.undefined_sel = 1'b1;
                    end
                end
                aimux_pkg::CODE_AIN2: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_AIN2;
                    if (pc[aimux_pkg::PAIR_AIN23]) begin
                        r.neg_src = aimux_pkg::AIMUX_SRC_AIN3;
                        r.differential = 1'b1;
                    end
                end
                aimux_pkg::CODE_AIN3: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_AIN3;
                    if (pc[aimux_pkg::PAIR_AIN23]) begin
                        r.pos_src = aimux_pkg::AIMUX_SRC_NONE;
                        r.undefined_sel = 1'b1;
                    end
                end
                aimux_pkg::CODE_AMP: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_AMP;
                    if (pc[aimux_pkg::PAIR_AMP]) begin
                        r.neg_src = aimux_pkg::AIMUX_SRC_AMPREF;
                        r.differential = 1'b1;
                    end
                end
                aimux_pkg::CODE_AGND: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_AGND;
                    if (pc[aimux_pkg::PAIR_AMP]) begin
                        r.pos_src = aimux_pkg::AIMUX_SRC_NONE;
                        r.undefined_sel = 1'b1;
                    end
                end
                aimux_pkg::CODE_EVEN: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_EVEN;
                    if (pc[aimux_pkg::PAIR_PORT]) begin
                        r.neg_src = aimux_pkg::AIMUX_SRC_ODD;
                        r.differential = 1'b1;
                    end
                end
                aimux_pkg::CODE_ODD: begin
                    r.pos_src = aimux_pkg::AIMUX_SRC_ODD;
                    if (pc[aimux_pkg::PAIR_PORT]) begin
                        r.pos_src = aimux_pkg::AIMUX_SRC_NONE;
                        r.undefined_sel = 1'b1;
                    end
                end
                default: r.pos_src = aimux_pkg::AIMUX_SRC_NONE;
            endcase
        end
        // pin switches split by parity; hardware does not stop a short
        r.even_pins = even_sw;
        r.odd_pins  = odd_sw;
        r.pin_short = (|r.even_pins) && (|r.odd_pins);
        s_d.route = r;

        if (sys_rst) begin
            s_d.port_pin_en  = aimux_pkg::RST_PORT_PIN_EN;
            s_d.channel_code = aimux_pkg::RST_CHANNEL;
            s_d.pair_cfg     = aimux_pkg::RST_PAIR;
            s_d.prdata       = 32'h00000000;
            s_d.route        = '0;
        end
    end

    // single state register
    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end
endmodule : aimux_top

// >>> src/aimux_pkg.sv
// package for the analog input mux select register bank
// assumes an apb slave host and an analog switch network downstream
package aimux_pkg;
    // register indices; pair config takes the next free word
    localparam int IDX_PORT_PIN_EN  = 32'h000000BA;
    localparam int IDX_CHANNEL_SEL  = 32'h000000BB;
    localparam int IDX_PAIR_CONFIG  = 32'h000000BC;
    // register byte addresses on the apb bus: four times the index
    localparam logic [11:0] ADDR_PORT_PIN_EN = 12'(IDX_PORT_PIN_EN * 4);
    localparam logic [11:0] ADDR_CHANNEL_SEL = 12'(IDX_CHANNEL_SEL * 4);
    localparam logic [11:0] ADDR_PAIR_CONFIG = 12'(IDX_PAIR_CONFIG * 4);
    // field layout
    localparam int CODE_W = 4;
    localparam int PAIR_W = 4;
    localparam int PINS_W = 8;
    localparam int PAIR_AIN01 = 0;
    localparam int PAIR_AIN23 = 1;
    localparam int PAIR_AMP   = 2;
    localparam int PAIR_PORT  = 3;
    // reset values
    localparam logic [7:0] RST_PORT_PIN_EN = 8'h00;
    localparam logic [3:0] RST_CHANNEL     = 4'h0;
    localparam logic [3:0] RST_PAIR        = 4'h0;
    // channel codes
    localparam logic [3:0] CODE_AIN0 = 4'h0;
    localparam logic [3:0] CODE_AIN1 = 4'h1;
    localparam logic [3:0] CODE_AIN2 = 4'h2;
    localparam logic [3:0] CODE_AIN3 = 4'h3;
    localparam logic [3:0] CODE_AMP  = 4'h4;
    localparam logic [3:0] CODE_AGND = 4'h5;
    localparam logic [3:0] CODE_EVEN = 4'h6;
    localparam logic [3:0] CODE_ODD  = 4'h7;

    // analog sources, binary-coded switch select per converter input
    typedef enum logic [3:0] {
        AIMUX_SRC_NONE, AIMUX_SRC_AIN0, AIMUX_SRC_AIN1, AIMUX_SRC_AIN2,
        AIMUX_SRC_AIN3, AIMUX_SRC_AMP, AIMUX_SRC_AMPREF, AIMUX_SRC_AGND,
        AIMUX_SRC_EVEN, AIMUX_SRC_ODD, AIMUX_SRC_TEMP
    } aimux_src_t;

    // routing presented to the switch network
    typedef struct packed {
        aimux_src_t pos_src;
        aimux_src_t neg_src;
        logic       differential;
        logic       undefined_sel;
        logic [7:0] even_pins;
        logic [7:0] odd_pins;
        logic       pin_short;
    } aimux_route_t;

    // all register state
    typedef struct packed {
        logic [7:0]  port_pin_en;
        logic [3:0]  channel_code;
        logic [3:0]  pair_cfg;
        logic [31:0] prdata;
        aimux_route_t route;
    } aimux_state_t;
endpackage : aimux_pkg

// >>> bench/aimux_switch_net.sv
// model of the analog switch network fed by the route outputs
// assumes route is a settled level from aimux_top
`timescale 1ns/100ps
module aimux_switch_net (
    input  wire aimux_pkg::aimux_route_t route,
    output logic                         grp_short
);
    // one wired-or node once both groups hold a pin
    assign grp_short = |route.even_pins && |route.odd_pins;
endmodule : aimux_switch_net

// >>> bench/aimux_checker.sv
// assertions on the aimux_top ports
// assumes a bind onto aimux_top, one clock domain
`timescale 1ns/100ps
module aimux_checker (
    input wire logic                    core_clk,
    input wire logic                    sys_rst,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire aimux_pkg::aimux_route_t route,
    input wire logic                    result_twos_complement
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic wr, wr_cs, wr_pp;
    // accepted writes; route follows two edges later
    assign wr = psel && penable && pwrite && pstrb[0];
    assign wr_cs = wr && paddr == aimux_pkg::ADDR_CHANNEL_SEL;
    assign wr_pp = wr && paddr == aimux_pkg::ADDR_PORT_PIN_EN;
    upper_zero_a: assert property (
        psel && penable && !pwrite && paddr == aimux_pkg::ADDR_CHANNEL_SEL
        |-> prdata[31:4] == 28'h0) else $error("channel upper bits set");
    amp_pos_a: assert property (
        wr_cs && pwdata[3:0] == aimux_pkg::CODE_AMP
        |-> ##2 route.pos_src == aimux_pkg::AIMUX_SRC_AMP)
        else $error("amplifier not on positive leg");
    temp_code_a: assert property (
        wr_cs && pwdata[3]
        |-> ##2 route.pos_src == aimux_pkg::AIMUX_SRC_TEMP)
        else $error("sensor code misrouted");
    pin_en_a: assert property (
        wr_pp |-> ##2 (route.even_pins == ($past(pwdata[7:0], 2) & 8'h55)
        && route.odd_pins == ($past(pwdata[7:0], 2) & 8'hAA)))
        else $error("pin enables lost");
    pin_split_a: assert property (
        (route.even_pins & 8'hAA) == 8'h00) else $error("odd pin in even");
    short_flag_a: assert property (
        wr_pp |-> ##2 route.pin_short ==
            ((|($past(pwdata[7:0], 2) & 8'h55)) &&
             (|($past(pwdata[7:0], 2) & 8'hAA))))
        else $error("short flag wrong");
    amp_ref_a: assert property (
        route.neg_src == aimux_pkg::AIMUX_SRC_AMPREF
        |-> route.pos_src == aimux_pkg::AIMUX_SRC_AMP && route.differential)
        else $error("reference without amplifier");
    twos_flag_a: assert property (
        result_twos_complement == (route.neg_src inside {
            aimux_pkg::AIMUX_SRC_AIN1, aimux_pkg::AIMUX_SRC_AIN3,
            aimux_pkg::AIMUX_SRC_AMPREF, aimux_pkg::AIMUX_SRC_ODD}))
        else $error("format flag wrong");
    cover property (wr_cs);
    cover property (route.pin_short);
    cover property (route.neg_src == aimux_pkg::AIMUX_SRC_AMPREF);
endmodule : aimux_checker

// >>> bench/test_analog_input_mux_select.sv
// bench for aimux_top: apb master, route decode and pin checks
// assumes package, design, checker and switch model compiled first
`timescale 1ns/100ps
module test_analog_input_mux_select;
    logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0;
    logic        pwrite = 0, pready, pslverr, err, twos, grp_short;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  v;
    logic [3:0]  pstrb = 4'hF, strb = 4'hF, cv, pv;
    logic        sh;
    int          error_cnt = 0, checked = 0, cyc = 0, seed = 32'hE2DE;
    aimux_pkg::aimux_route_t route;
    localparam logic [11:0] CS = aimux_pkg::ADDR_CHANNEL_SEL;
    localparam logic [11:0] PP = aimux_pkg::ADDR_PORT_PIN_EN;
    localparam logic [11:0] PC = aimux_pkg::ADDR_PAIR_CONFIG;
    // only lane zero carries data; a cleared lane zero drops a write
    aimux_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .route(route), .result_twos_complement(twos));
    aimux_switch_net net (.route(route), .grp_short(grp_short));
    always #5 core_clk = ~core_clk;
    // hang guard, far above the roughly 1500 cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // request held until pready is sampled high at an edge
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // write, then let register and decode stages land
    task automatic wrs(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (2) @(posedge core_clk);
        #1;
    endtask : wrs
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdchk
    // positive leg by code; enum order puts even and odd after ground
    function automatic aimux_pkg::aimux_src_t exp_pos(logic [3:0] c);
        if (c[3]) return aimux_pkg::AIMUX_SRC_TEMP;
        if (c == 4'h5) return aimux_pkg::AIMUX_SRC_AGND;
        return aimux_pkg::aimux_src_t'(c + ((c > 4'h5) ? 4'h2 : 4'h1));
    endfunction : exp_pos
    function automatic aimux_pkg::aimux_src_t exp_neg(logic [3:0] c, p);
        if (!c[3] && !c[0] && p[c[2:1]])
            return aimux_pkg::aimux_src_t'(c + 4'h2 + (c == 4'h6));
        return aimux_pkg::AIMUX_SRC_AGND;
    endfunction : exp_neg
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdchk(PP, 32'h0, "pins reset");
        rdchk(CS, 32'h0, "chan reset");
        rdchk(PC, 32'h0, "pair reset");
        wrs(CS, 32'hFF);
        rdchk(CS, 32'hF, "chan mask");
        chk("slverr ok", 32'h0, err);
        strb = 4'hE;
        wrs(CS, 32'h3);
        strb = 4'hF;
        rdchk(CS, 32'hF, "strobe off");
        wrs(12'h0F0, 32'h5A);
        rdchk(12'h0F0, 32'h0, "unmapped");
        chk("slverr", 32'h1, err);
        for (int p = 0; p < 16; p++) begin
            wrs(PC, p);
            rdchk(PC, p, "pair");
            for (int c = 0; c < 16; c++) begin
                // second code of a paired channel is left alone
                if (c[0] && !c[3] && p[c[2:1]]) continue;
                cv = 4'(c);
                pv = 4'(p);
                wrs(CS, c);
                chk("pos", exp_pos(cv), route.pos_src);
                chk("neg", exp_neg(cv, pv), route.neg_src);
                chk("undef", 32'h0, route.undefined_sel);
                v = {7'h00, exp_neg(cv, pv) != aimux_pkg::AIMUX_SRC_AGND};
                chk("twos", v, twos);
            end
        end
        // corner masks first, then random enable sets
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h55 : 8'($random(seed));
            wrs(PP, v);
            rdchk(PP, v, "pins");
            chk("even", v & 8'h55, route.even_pins);
            chk("odd", v & 8'hAA, route.odd_pins);
            sh = |(v & 8'h55) && |(v & 8'hAA);
            chk("short", sh, grp_short);
            chk("flag", sh, route.pin_short);
        end
        tally_and_finish;
    end
endmodule : test_analog_input_mux_select
bind aimux_top aimux_checker chk_i (.*);
